/* File: bench/wdcf_tb.sv */
// Self-checking bench for the watchdog control and flags block.
// Assumes wdcf_top alone; the bench drives the register port and reset pins itself.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  // Design connections
  logic                clk_sys_i;
  logic                reset_n_i;
  logic                ext_reset_i;
  logic                power_down_i;
  wdcf_pkg::wdcf_sfr_s sfr_i;
  logic [7:0]          sfr_rdata_o;
  logic                sfr_hit_o;
  logic [1:0]          wd_interval_i;
  logic                wdt_irq_o;
  logic                wdt_irq_priority_o;
  logic                wdt_reset_o;
  // Bookkeeping
  int                  n_mismatch;
  int                  comparisons;
  int                  n;

  wdcf_top dut_u (
    .clk_sys_i          (clk_sys_i),
    .reset_n_i          (reset_n_i),
    .ext_reset_i        (ext_reset_i),
    .power_down_i       (power_down_i),
    .sfr_i              (sfr_i),
    .sfr_rdata_o        (sfr_rdata_o),
    .sfr_hit_o          (sfr_hit_o),
    .wd_interval_i      (wd_interval_i),
    .wdt_irq_o          (wdt_irq_o),
    .wdt_irq_priority_o (wdt_irq_priority_o),
    .wdt_reset_o        (wdt_reset_o)
  );

  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  task automatic summarize();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic sfr_write(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk_sys_i);
    sfr_i <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
    @(posedge clk_sys_i);
    sfr_i <= '0;
  endtask

  // Read answer is registered, so it is looked at just after the taking edge
  task automatic rd_chk(input string name, input logic [7:0] addr, input logic [7:0] exp);
    logic mapped;
    mapped = (addr == 8'hd8) || (addr == 8'he8) || (addr == 8'hf8);
    @(posedge clk_sys_i);
    sfr_i <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
    @(posedge clk_sys_i);
    sfr_i <= '0;
    #1;
    check({name, " hit"}, {7'h00, sfr_hit_o}, {7'h00, mapped});
    check(name, sfr_rdata_o, exp);
  endtask

  // Keys on consecutive edges; idle edges between keys are tried in the tests
  task automatic unlock();
    @(posedge clk_sys_i);
    sfr_i <= '{wr: 1'b1, rd: 1'b0, addr: 8'hc7, wdata: 8'haa};
    @(posedge clk_sys_i);
    sfr_i <= '{wr: 1'b1, rd: 1'b0, addr: 8'hc7, wdata: 8'h55};
    @(posedge clk_sys_i);
    sfr_i <= '0;
  endtask

  task automatic por();
    @(posedge clk_sys_i);
    reset_n_i <= 1'b0;
    repeat (10) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
  endtask

  task automatic wait_high(input bit pick_reset, input int limit);
    n = 0;
    while ((pick_reset ? wdt_reset_o : wdt_irq_o) !== 1'b1 && n < limit) begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
  endtask

  // Shortest interval is 2^16 clocks; the watchdog leaves room for one time-out
  initial begin
    repeat (90000) @(posedge clk_sys_i);
    n_mismatch++;
    summarize();
  end

  initial begin
    n_mismatch    = 0;
    comparisons   = 0;
    reset_n_i     = 1'b0;
    ext_reset_i   = 1'b0;
    power_down_i  = 1'b0;
    wd_interval_i = 2'b00;
    sfr_i         = '0;
    por();
    rd_chk("control after power-on", 8'hd8, 8'h40);
    rd_chk("enable reserved bits", 8'he8, 8'he0);
    rd_chk("unmapped read", 8'hc7, 8'h00);
    sfr_write(8'hd8, 8'h4f);
    rd_chk("locked write", 8'hd8, 8'h44);
    unlock();
    sfr_write(8'hd8, 8'h00);
    rd_chk("unlocked clear", 8'hd8, 8'h00);
    // Window must run out first, then a foreign write between keys breaks them
    repeat (12) @(posedge clk_sys_i);
    sfr_write(8'hc7, 8'haa);
    sfr_write(8'he8, 8'he0);
    sfr_write(8'hc7, 8'h55);
    sfr_write(8'hd8, 8'h02);
    rd_chk("broken key", 8'hd8, 8'h00);
    // Idle edges between the keys keep the first half
    sfr_write(8'hc7, 8'haa);
    sfr_write(8'hc7, 8'h55);
    sfr_write(8'hd8, 8'h03);
    repeat (2) @(posedge clk_sys_i);
    rd_chk("restart self clear", 8'hd8, 8'h02);
    unlock();
    sfr_write(8'hd8, 8'h4e);
    rd_chk("protected set", 8'hd8, 8'h4e);
    @(posedge clk_sys_i);
    ext_reset_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    ext_reset_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    rd_chk("after external reset", 8'hd8, 8'h46);
    unlock();
    sfr_write(8'hd8, 8'h02);
    rd_chk("reset enable armed", 8'hd8, 8'h02);
    sfr_write(8'he8, 8'h10);
    rd_chk("irq enable", 8'he8, 8'hf0);
    sfr_write(8'hf8, 8'h10);
    repeat (2) @(posedge clk_sys_i);
    check("priority high", {7'h00, wdt_irq_priority_o}, 8'h01);
    sfr_write(8'hf8, 8'h00);
    repeat (2) @(posedge clk_sys_i);
    check("priority low", {7'h00, wdt_irq_priority_o}, 8'h00);
    wait_high(1'b0, 70000);
    check("time-out irq", {7'h00, wdt_irq_o}, 8'h01);
    // Power-down for 20 edges freezes the delay; 21 edges pass before counting starts
    @(posedge clk_sys_i);
    power_down_i <= 1'b1;
    repeat (20) @(posedge clk_sys_i);
    power_down_i <= 1'b0;
    wait_high(1'b1, 600);
    check("reset delay", {7'h00, n == 512 + 20 - 21}, 8'h01);
    repeat (4) @(posedge clk_sys_i);
    rd_chk("after watchdog reset", 8'hd8, 8'h06);
    check("irq after reset", {7'h00, wdt_irq_o}, 8'h00);
    por();
    rd_chk("power-on clears cause", 8'hd8, 8'h40);
    summarize();
  end
endmodule
`default_nettype wire

/* File: core/wdcf_counter.sv */
// Free-running watchdog counter with selectable terminal count.
// Assumes clk_sys_i domain and a synchronised active-low reset.
`timescale 1ns/100ps
`default_nettype none
module wdcf_counter (
  // Clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  // Control
  input  wire logic       run_i,
  input  wire logic       restart_i,
  input  wire logic [1:0] sel_i,
  // Status
  output logic            timeout_o
);

  logic [wdcf_pkg::WDCF_CNT_W-1:0] cnt_r;
  logic [wdcf_pkg::WDCF_CNT_W-1:0] cnt_nxt;
  logic [wdcf_pkg::WDCF_CNT_W-1:0] term;

  // Interval select: 2^16, 2^20, 2^23, 2^26 clocks
  // Shortest code kept at 2^16 so a time-out is reachable in a short run
  function automatic logic [wdcf_pkg::WDCF_CNT_W-1:0] term_of(input logic [1:0] s);
    logic [wdcf_pkg::WDCF_CNT_W-1:0] t;
    t = '0;
    unique case (s)
      2'b00: t = {{(wdcf_pkg::WDCF_CNT_W-16){1'b0}}, {16{1'b1}}};
      2'b01: t = {{(wdcf_pkg::WDCF_CNT_W-20){1'b0}}, {20{1'b1}}};
      2'b10: t = {{(wdcf_pkg::WDCF_CNT_W-23){1'b0}}, {23{1'b1}}};
      2'b11: t = {wdcf_pkg::WDCF_CNT_W{1'b1}};
    endcase
    return t;
  endfunction

  always_comb begin
    term      = term_of(sel_i);
    timeout_o = run_i && (cnt_r == term);
    cnt_nxt   = cnt_r;
    if (restart_i) begin
      cnt_nxt = '0;
    end else if (run_i) begin
      cnt_nxt = timeout_o ? '0 : cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  a_restart_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    restart_i |=> cnt_r == '0)
    else $error("counter not cleared by restart");

endmodule
`default_nettype wire

/* File: core/wdcf_pkg.sv */
// Package for the watchdog control and flags block.
// Assumes an internal special-function register port with 8-bit address and data.
package wdcf_pkg;

  // Register addresses on the special-function register port
  localparam logic [7:0] WDCF_ADDR_WDCTL = 8'hd8;
  localparam logic [7:0] WDCF_ADDR_EIE   = 8'he8;
  localparam logic [7:0] WDCF_ADDR_EIP   = 8'hf8;
  localparam logic [7:0] WDCF_ADDR_TAKEY = 8'hc7;
  localparam logic [7:0] WDCF_ADDR_CLOCK_CONTROL_REG = 8'h8e;

  // Watchdog control bit positions
  localparam int WDCF_BIT_RESTART = 0;
  localparam int WDCF_BIT_RSTEN   = 1;
  localparam int WDCF_BIT_RFLAG   = 2;
  localparam int WDCF_BIT_IFLAG   = 3;
  localparam int WDCF_BIT_POR     = 6;
  // Bits kept across an external reset (x positions of 0x0x0xx0)
  localparam logic [7:0] WDCF_EXT_KEEP_MASK = 8'h56;
  // Bits that need the timed-access window to be written
  localparam logic [7:0] WDCF_PROT_MASK     = 8'h4b;

  // Extended interrupt enable and priority
  localparam int         WDCF_BIT_WDI     = 4;
  localparam logic [7:0] WDCF_EIE_RSVD    = 8'he0;
  localparam logic [7:0] WDCF_EIE_RESET   = 8'he0;
  localparam logic [7:0] WDCF_EIP_RESET   = 8'he0;

  // Timed-access keys and window
  localparam logic [7:0] WDCF_KEY_FIRST   = 8'haa;
  localparam logic [7:0] WDCF_KEY_SECOND  = 8'h55;
  localparam int         WDCF_CLK_PER_MC  = 4;
  localparam int         WDCF_TA_MC       = 3;
  localparam logic [3:0] WDCF_TA_CYCLES   = 4'(WDCF_TA_MC * WDCF_CLK_PER_MC);

  // Watchdog timing
  localparam logic [9:0] WDCF_RST_DELAY   = 10'd512;
  localparam int         WDCF_CNT_W       = 26;
  localparam int         WDCF_CLOCK_CONTROL_REG_WD_LSB = 6;

  // Reset source as seen by the flag logic
  typedef enum logic [1:0] {
    WDCF_SRC_NONE,
    WDCF_SRC_EXT,
    WDCF_SRC_WDT
  } wdcf_src_e;

  // Special-function register access
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } wdcf_sfr_s;

endpackage

/* File: core/wdcf_top.sv */
// Watchdog control and flags: control register, timed access, delayed reset.
// Assumes CPU reaches registers over an internal SFR port on clk_sys_i.
// Summary of operation
// - Power-on flag set at power-up, software clears
// - Time-out sets interrupt flag regardless of enable
// - Watchdog reset sets reset flag until cleared
// - Reset enable low: reset flag untouched
// - Reset enable arms watchdog reset function
// - Restart write returns counter to start
// - Restart bit clears itself after use
// - Interrupt requested when enable bit four set
// - Reset follows time-out by 512 clocks
// - External reset loads 0x0x0xx0 pattern
// - Watchdog reset sets flag, power-on clears
// - External reset keeps reset flag
// - Power-on sets power flag, clears enable
// - Control register always readable
// - Protected bits need open timed window
// - Enable register top three read one
// - Priority bit sets watchdog interrupt level
// - Clock control top bits select interval
// - Keys AAh then 55h open window
// - Counts in idle, stops in power-down
`timescale 1ns/100ps
`default_nettype none
module wdcf_top (
  // Clock and power-on reset
  input  wire logic              clk_sys_i,
  input  wire logic              reset_n_i,
  // External reset pin, active high
  input  wire logic              ext_reset_i,
  // Power-down mode from the power manager
  input  wire logic              power_down_i,
  // SFR access from the CPU
  input  wire wdcf_pkg::wdcf_sfr_s sfr_i,
  output logic [7:0]             sfr_rdata_o,
  output logic                   sfr_hit_o,
  // Clock control interval bits
  input  wire logic [1:0]        wd_interval_i,
  // Interrupt and reset outputs
  output logic                   wdt_irq_o,
  output logic                   wdt_irq_priority_o,
  output logic                   wdt_reset_o
);

  logic rst_s1_r;
  logic rst_s2_r;
  logic ext_s1_r;
  logic ext_s2_r;

  // Power-on reset release through two flops
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  // External reset pin synchroniser
  always_ff @(posedge clk_sys_i or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
    end else begin
      ext_s1_r <= ext_reset_i;
      ext_s2_r <= ext_s1_r;
    end
  end

  logic       pd_s1_r;
  logic       pd_s2_r;
  always_ff @(posedge clk_sys_i or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      pd_s1_r <= 1'b0;
      pd_s2_r <= 1'b0;
    end else begin
      pd_s1_r <= power_down_i;
      pd_s2_r <= pd_s1_r;
    end
  end

  // State
  logic [7:0] wdctl_r;
  logic [7:0] wdctl_nxt;
  logic       wdi_en_r;
  logic       wdi_en_nxt;
  logic       wdi_pri_r;
  logic       wdi_pri_nxt;
  logic [4:0] eie_low_r;
  logic [4:0] eie_low_nxt;
  logic [4:0] eip_low_r;
  logic [4:0] eip_low_nxt;
  logic       key_half_r;
  logic       key_half_nxt;
  logic [3:0] ta_cnt_r;
  logic [3:0] ta_cnt_nxt;
  logic       pend_r;
  logic       pend_nxt;
  logic [9:0] dly_r;
  logic [9:0] dly_nxt;
  logic       wdt_rst_r;
  logic       wdt_rst_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic       hit_r;
  logic       hit_nxt;

  logic       timeout;
  logic       ta_open;
  logic       wr_wdctl;
  logic       run;
  wdcf_pkg::wdcf_src_e src;

  function automatic logic is_wr(input wdcf_pkg::wdcf_sfr_s s, input logic [7:0] a);
    return s.wr && (s.addr == a);
  endfunction

  // Idle keeps counting; power-down stops the watchdog clock
  assign run = !pd_s2_r;
  assign ta_open  = (ta_cnt_r != 4'h0);
  assign wr_wdctl = is_wr(sfr_i, wdcf_pkg::WDCF_ADDR_WDCTL);

  // Watchdog reset or external pin both act as synchronous block resets
  always_comb begin
    if (wdt_rst_r) begin
      src = wdcf_pkg::WDCF_SRC_WDT;
    end else if (ext_s2_r) begin
      src = wdcf_pkg::WDCF_SRC_EXT;
    end else begin
      src = wdcf_pkg::WDCF_SRC_NONE;
    end
  end

  wdcf_counter u_counter (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_s2_r),
    .run_i     (run && src == wdcf_pkg::WDCF_SRC_NONE),
    .restart_i (wdctl_r[wdcf_pkg::WDCF_BIT_RESTART] || src != wdcf_pkg::WDCF_SRC_NONE),
    .sel_i     (wd_interval_i),
    .timeout_o (timeout)
  );

  // Timed-access key sequencing
  always_comb begin
    key_half_nxt = 1'b0;
    ta_cnt_nxt   = ta_open ? ta_cnt_r - 4'h1 : 4'h0;
    if (is_wr(sfr_i, wdcf_pkg::WDCF_ADDR_TAKEY)) begin
      if (sfr_i.wdata == wdcf_pkg::WDCF_KEY_FIRST) begin
        key_half_nxt = 1'b1;
      end else if (key_half_r && sfr_i.wdata == wdcf_pkg::WDCF_KEY_SECOND) begin
        ta_cnt_nxt = wdcf_pkg::WDCF_TA_CYCLES;
      end
    end else if (sfr_i.wr) begin
      key_half_nxt = 1'b0;
    end else begin
      key_half_nxt = key_half_r;
    end
  end

  // Control register, enables and the delayed reset
  always_comb begin
    logic [7:0] mask;
    logic [7:0] w;
    mask        = '0;
    w           = wdctl_r;
    wdctl_nxt   = wdctl_r;
    wdi_en_nxt  = wdi_en_r;
    wdi_pri_nxt = wdi_pri_r;
    eie_low_nxt = eie_low_r;
    eip_low_nxt = eip_low_r;
    pend_nxt    = pend_r;
    dly_nxt     = dly_r;
    wdt_rst_nxt = 1'b0;
    unique case (src)
      wdcf_pkg::WDCF_SRC_WDT: begin
        wdctl_nxt = wdctl_r & wdcf_pkg::WDCF_EXT_KEEP_MASK;
        wdctl_nxt[wdcf_pkg::WDCF_BIT_RFLAG] = 1'b1;
        pend_nxt  = 1'b0;
        dly_nxt   = '0;
      end
      wdcf_pkg::WDCF_SRC_EXT: begin
        wdctl_nxt = wdctl_r & wdcf_pkg::WDCF_EXT_KEEP_MASK;
        pend_nxt  = 1'b0;
        dly_nxt   = '0;
      end
      wdcf_pkg::WDCF_SRC_NONE: begin
        // Self-clearing restart
        wdctl_nxt[wdcf_pkg::WDCF_BIT_RESTART] = 1'b0;
        if (wr_wdctl) begin
          mask = ta_open ? 8'hff : ~wdcf_pkg::WDCF_PROT_MASK;
          w    = (sfr_i.wdata & mask) | (wdctl_nxt & ~mask);
          wdctl_nxt = w;
        end
        if (is_wr(sfr_i, wdcf_pkg::WDCF_ADDR_EIE)) begin
          wdi_en_nxt  = sfr_i.wdata[wdcf_pkg::WDCF_BIT_WDI];
          eie_low_nxt = sfr_i.wdata[4:0];
        end
        if (is_wr(sfr_i, wdcf_pkg::WDCF_ADDR_EIP)) begin
          wdi_pri_nxt = sfr_i.wdata[wdcf_pkg::WDCF_BIT_WDI];
          eip_low_nxt = sfr_i.wdata[4:0];
        end
        // Set wins over a same-cycle software clear
        if (timeout) begin
          wdctl_nxt[wdcf_pkg::WDCF_BIT_IFLAG] = 1'b1;
        end
        if (wdctl_nxt[wdcf_pkg::WDCF_BIT_RESTART] || wdctl_r[wdcf_pkg::WDCF_BIT_RESTART]) begin
          pend_nxt = 1'b0;
          dly_nxt  = '0;
        end else if (timeout && wdctl_r[wdcf_pkg::WDCF_BIT_RSTEN]) begin
          pend_nxt = 1'b1;
          dly_nxt  = '0;
        end else if (pend_r && run) begin
          dly_nxt = dly_r + 10'd1;
          if (dly_nxt == wdcf_pkg::WDCF_RST_DELAY) begin
            // Enable cleared meanwhile leaves the reset flag alone
            wdt_rst_nxt = wdctl_r[wdcf_pkg::WDCF_BIT_RSTEN];
            pend_nxt    = 1'b0;
          end
        end
      end
      default: begin
        wdctl_nxt = wdctl_r;
      end
    endcase
  end

  // Read path, one cycle after the read strobe
  always_comb begin
    hit_nxt   = 1'b0;
    rdata_nxt = 8'h00;
    if (sfr_i.rd) begin
      hit_nxt = 1'b1;
      if (sfr_i.addr == wdcf_pkg::WDCF_ADDR_WDCTL) begin
        rdata_nxt = wdctl_r;
      end else if (sfr_i.addr == wdcf_pkg::WDCF_ADDR_EIE) begin
        rdata_nxt = wdcf_pkg::WDCF_EIE_RSVD | {3'b000, eie_low_r};
      end else if (sfr_i.addr == wdcf_pkg::WDCF_ADDR_EIP) begin
        rdata_nxt = {3'b000, eip_low_r};
      end else begin
        hit_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      // Power-on: power flag set, all else clear
      wdctl_r    <= 8'h40;
      eie_low_r  <= '0;
      eip_low_r  <= '0;
      wdi_en_r   <= 1'b0;
      wdi_pri_r  <= 1'b0;
      key_half_r <= 1'b0;
      ta_cnt_r   <= 4'h0;
      pend_r     <= 1'b0;
      dly_r      <= '0;
      wdt_rst_r  <= 1'b0;
      rdata_r    <= 8'h00;
      hit_r      <= 1'b0;
    end else begin
      wdctl_r    <= wdctl_nxt;
      eie_low_r  <= eie_low_nxt;
      eip_low_r  <= eip_low_nxt;
      wdi_en_r   <= wdi_en_nxt;
      wdi_pri_r  <= wdi_pri_nxt;
      key_half_r <= key_half_nxt;
      ta_cnt_r   <= ta_cnt_nxt;
      pend_r     <= pend_nxt;
      dly_r      <= dly_nxt;
      wdt_rst_r  <= wdt_rst_nxt;
      rdata_r    <= rdata_nxt;
      hit_r      <= hit_nxt;
    end
  end

  assign sfr_rdata_o        = rdata_r;
  assign sfr_hit_o          = hit_r;
  assign wdt_irq_o          = wdctl_r[wdcf_pkg::WDCF_BIT_IFLAG] && wdi_en_r;
  assign wdt_irq_priority_o = wdi_pri_r;
  assign wdt_reset_o        = wdt_rst_r;

  // Checks
  sequence s_key_pair;
    is_wr(sfr_i, wdcf_pkg::WDCF_ADDR_TAKEY) && sfr_i.wdata == wdcf_pkg::WDCF_KEY_FIRST
    ##1 is_wr(sfr_i, wdcf_pkg::WDCF_ADDR_TAKEY) && sfr_i.wdata == wdcf_pkg::WDCF_KEY_SECOND;
  endsequence

  a_key_opens: assert property (@(posedge clk_sys_i) disable iff (!rst_s2_r)
    s_key_pair |=> ta_open [*8])
    else $error("key pair did not open window");

  a_prot_locked: assert property (@(posedge clk_sys_i) disable iff (!rst_s2_r)
    (wr_wdctl && !ta_open && src == wdcf_pkg::WDCF_SRC_NONE && !timeout)
    |=> wdctl_r[6] == $past(wdctl_r[6]) && wdctl_r[1] == $past(wdctl_r[1]))
    else $error("protected bit written without window");

  a_iflag_set: assert property (@(posedge clk_sys_i) disable iff (!rst_s2_r)
    (timeout && src == wdcf_pkg::WDCF_SRC_NONE) |=> wdctl_r[wdcf_pkg::WDCF_BIT_IFLAG])
    else $error("timeout did not set interrupt flag");

  a_restart_clr: assert property (@(posedge clk_sys_i) disable iff (!rst_s2_r)
    wdctl_r[wdcf_pkg::WDCF_BIT_RESTART] && !wr_wdctl |=> !wdctl_r[wdcf_pkg::WDCF_BIT_RESTART])
    else $error("restart bit not self-cleared");

  a_rst_delay: assert property (@(posedge clk_sys_i) disable iff (!rst_s2_r)
    $rose(wdt_rst_r) |-> $past(pend_r) && $past(dly_r) == 10'd511)
    else $error("watchdog reset not 512 clocks after timeout");

  a_rflag_wdt: assert property (@(posedge clk_sys_i) disable iff (!rst_s2_r)
    wdt_rst_r |=> wdctl_r[wdcf_pkg::WDCF_BIT_RFLAG])
    else $error("reset flag not set by watchdog reset");

  a_ext_keep: assert property (@(posedge clk_sys_i) disable iff (!rst_s2_r)
    (src == wdcf_pkg::WDCF_SRC_EXT) |=> wdctl_r[wdcf_pkg::WDCF_BIT_RFLAG] == $past(wdctl_r[2])
      && wdctl_r[0] == 1'b0 && wdctl_r[3] == 1'b0)
    else $error("external reset pattern wrong");

  a_irq_gate: assert property (@(posedge clk_sys_i) disable iff (!rst_s2_r)
    (timeout && wdi_en_nxt && src == wdcf_pkg::WDCF_SRC_NONE) |=> wdt_irq_o)
    else $error("enabled time-out did not request interrupt");

  a_eie_rsvd: assert property (@(posedge clk_sys_i) disable iff (!rst_s2_r)
    $past(sfr_i.rd && sfr_i.addr == wdcf_pkg::WDCF_ADDR_EIE) |-> sfr_rdata_o[7:5] == 3'b111)
    else $error("reserved enable bits not high");

endmodule
`default_nettype wire
